// ===== logic/csf_flags.sv
// status flag register, flag generation and conditional branch decision
`timescale 1ns/10ps
// Summary of operation
// - six status bits in flag register at FCh, updated by instruction side effects
// - user bits change only on explicit writes and interrupt return and cannot be jump conditions
// - watchdog refresh sets zero, clears sign and overflow
// - arithmetic carry is carry or borrow out of bit 7
// - rotate and shift put the last bit shifted out into carry
// - dedicated operations set, clear or invert carry
// - interrupt return reloads all flags from the popped image
// - arithmetic and logic zero flag marks a zero result
// - bit test zero flag marks a masked result of 00h
// - rotate and shift zero flag marks a result of 00h
// - sign flag copies bit 7 of the result
// - overflow marks a signed result outside -128 to 127
// - logical operations clear overflow
// - decimal flag set after subtraction, cleared after addition
// - half carry marks carry or borrow at bit 3
// - decimal adjust uses half carry and decimal flag to correct into BCD
// - only carry, overflow, zero, sign feed condition evaluation
// - condition selector is opcode bits 4 to 7
// - basic condition codes: never, always, carry, zero, sign, overflow pairs
// - signed compare codes built from S xor V and zero
// - unsigned compare codes built from carry and zero
module csf_flags (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire csf_pkg::csf_req_t req_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic [7:0] flags_o,
    output logic [7:0] adj_result_o,
    output logic taken_o
);
    csf_pkg::csf_state_t st;
    csf_pkg::csf_state_t next_st;

    logic fc, fz, fs, fv, fd, fh;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic cin;
    logic is_sub;
    logic decide;
    logic [7:0] corr;
    logic [7:0] adj_val;
    logic adj_c;

    assign fc = st.flags[csf_pkg::CSF_BIT_C];
    assign fz = st.flags[csf_pkg::CSF_BIT_Z];
    assign fs = st.flags[csf_pkg::CSF_BIT_S];
    assign fv = st.flags[csf_pkg::CSF_BIT_V];
    assign fd = st.flags[csf_pkg::CSF_BIT_D];
    assign fh = st.flags[csf_pkg::CSF_BIT_H];

    // recompute carries from the operands so bit 7 and bit 3 carries are exact
    always_comb begin
        is_sub = (req_i.op == csf_pkg::CSF_OP_SUB) || (req_i.op == csf_pkg::CSF_OP_SBC);
        cin = ((req_i.op == csf_pkg::CSF_OP_ADC) || (req_i.op == csf_pkg::CSF_OP_SBC)) & fc;
        if (is_sub) begin
            sum9 = {1'b0, req_i.dst} - {1'b0, req_i.src} - {8'h00, cin};
            sum5 = {1'b0, req_i.dst[3:0]} - {1'b0, req_i.src[3:0]} - {4'h0, cin};
        end else begin
            sum9 = {1'b0, req_i.dst} + {1'b0, req_i.src} + {8'h00, cin};
            sum5 = {1'b0, req_i.dst[3:0]} + {1'b0, req_i.src[3:0]} + {4'h0, cin};
        end
    end

    // decimal correction: direction from D, low nibble from H, high from C
    always_comb begin
        corr = csf_pkg::CSF_ZERO;
        adj_c = fc;
        if (fh || (!fd && (req_i.dst[3:0] > csf_pkg::CSF_BCD_LIMIT))) begin
            corr = corr | csf_pkg::CSF_BCD_LO;
        end
        if (fc || (!fd && (req_i.dst > csf_pkg::CSF_BCD_HI_LIMIT))) begin
            corr = corr | csf_pkg::CSF_BCD_HI;
            adj_c = 1'b1;
        end
        adj_val = fd ? (req_i.dst - corr) : (req_i.dst + corr);
    end

    // one update per request; last write is kept when no flag-affecting op runs
    always_comb begin
        next_st = st;
        if (req_i.valid) begin
            unique case (req_i.op)
                csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADC,
                csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SBC: begin
                    next_st.flags[csf_pkg::CSF_BIT_C] = sum9[8];
                    next_st.flags[csf_pkg::CSF_BIT_Z] = (sum9[7:0] == csf_pkg::CSF_ZERO);
                    next_st.flags[csf_pkg::CSF_BIT_S] = sum9[7];
                    // signed range exceeded when the sign of the result is impossible
                    next_st.flags[csf_pkg::CSF_BIT_V] = is_sub ?
                        ((req_i.dst[7] ^ req_i.src[7]) & (req_i.dst[7] ^ sum9[7])) :
                        (~(req_i.dst[7] ^ req_i.src[7]) & (req_i.dst[7] ^ sum9[7]));
                    next_st.flags[csf_pkg::CSF_BIT_D] = is_sub;
                    next_st.flags[csf_pkg::CSF_BIT_H] = sum5[4];
                end
                csf_pkg::CSF_OP_INCDEC: begin
                    // increment and decrement leave carry, half and decimal alone
                    next_st.flags[csf_pkg::CSF_BIT_Z] = (req_i.res == csf_pkg::CSF_ZERO);
                    next_st.flags[csf_pkg::CSF_BIT_S] = req_i.res[7];
                    // only 7Fh up or 80h down flips the sign by leaving the signed range
                    next_st.flags[csf_pkg::CSF_BIT_V] = (req_i.dst[7] ^ req_i.res[7]) &
                        (req_i.dst[7] ^ req_i.dst[6]);
                end
                csf_pkg::CSF_OP_LOGIC: begin
                    next_st.flags[csf_pkg::CSF_BIT_Z] = (req_i.res == csf_pkg::CSF_ZERO);
                    next_st.flags[csf_pkg::CSF_BIT_S] = req_i.res[7];
                    next_st.flags[csf_pkg::CSF_BIT_V] = 1'b0;
                end
                csf_pkg::CSF_OP_BITTEST: begin
                    next_st.flags[csf_pkg::CSF_BIT_Z] = (req_i.res == csf_pkg::CSF_ZERO);
                    next_st.flags[csf_pkg::CSF_BIT_S] = req_i.res[7];
                    next_st.flags[csf_pkg::CSF_BIT_V] = 1'b0;
                end
                csf_pkg::CSF_OP_SHIFT: begin
                    next_st.flags[csf_pkg::CSF_BIT_C] = req_i.shout;
                    next_st.flags[csf_pkg::CSF_BIT_Z] = (req_i.res == csf_pkg::CSF_ZERO);
                    next_st.flags[csf_pkg::CSF_BIT_S] = req_i.res[7];
                    // a sign change during the shift means the signed value left range
                    next_st.flags[csf_pkg::CSF_BIT_V] = req_i.dst[7] ^ req_i.res[7];
                end
                csf_pkg::CSF_OP_SCF: next_st.flags[csf_pkg::CSF_BIT_C] = 1'b1;
                csf_pkg::CSF_OP_RCF: next_st.flags[csf_pkg::CSF_BIT_C] = 1'b0;
                csf_pkg::CSF_OP_CCF: next_st.flags[csf_pkg::CSF_BIT_C] = ~fc;
                csf_pkg::CSF_OP_WDT: begin
                    next_st.flags[csf_pkg::CSF_BIT_Z] = 1'b1;
                    next_st.flags[csf_pkg::CSF_BIT_S] = 1'b0;
                    next_st.flags[csf_pkg::CSF_BIT_V] = 1'b0;
                end
                csf_pkg::CSF_OP_INTERRUPT_RETURN_INSTR: begin
                    // whole image comes back, user bits included, as the stack held them
                    next_st.flags = req_i.data;
                end
                csf_pkg::CSF_OP_DADJ: begin
                    next_st.adj = adj_val;
                    next_st.flags[csf_pkg::CSF_BIT_C] = adj_c;
                    next_st.flags[csf_pkg::CSF_BIT_Z] = (adj_val == csf_pkg::CSF_ZERO);
                    next_st.flags[csf_pkg::CSF_BIT_S] = adj_val[7];
                end
                csf_pkg::CSF_OP_WRITE: next_st.flags = req_i.data;
                csf_pkg::CSF_OP_NONE: next_st = st;
            endcase
        end
        // register file write at FCh; overrides any flag update from a request in the same cycle
        if (reg_wr_i && (reg_addr_i == csf_pkg::CSF_FLAGS_ADDR)) begin
            next_st.flags = reg_wdata_i;
        end
        next_st.taken = decide;
    end

    // condition field is opcode bits 7..4
    csf_cond_eval u_cond (
        .cc_i(opcode_i[csf_pkg::CSF_CC_MSB:csf_pkg::CSF_CC_LSB]),
        .c_i(fc),
        .z_i(fz),
        .s_i(fs),
        .v_i(fv),
        .taken_o(decide)
    );

    // state register
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '{flags: csf_pkg::CSF_FLAGS_RESET, adj: csf_pkg::CSF_ZERO, taken: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // unmapped addresses read zero
    assign reg_rdata_o = (reg_addr_i == csf_pkg::CSF_FLAGS_ADDR) ? st.flags : csf_pkg::CSF_ZERO;
    assign flags_o = st.flags;
    assign adj_result_o = st.adj;
    assign taken_o = st.taken;

    // sign-extended sum kept apart from the flag path, so the overflow check is independent
    logic [8:0] ssum;
    assign ssum = {req_i.dst[7], req_i.dst} + {req_i.src[7], req_i.src};

    // checks look one cycle after a request; a register write beside it would override all

    // refresh side effect
    a_wdt_forces_zs: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_WDT && !reg_wr_i |=>
        fz && !fs && !fv)
        else $error("refresh flag effect wrong");

    // carry from arithmetic, shifts and the dedicated carry operations
    a_arith_carry_out: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_ADD && !reg_wr_i |=>
        fc == ({1'b0, $past(req_i.dst)} + {1'b0, $past(req_i.src)} > 9'h0FF))
        else $error("add carry wrong");
    a_sub_borrow_out: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_SUB && !reg_wr_i |=>
        fc == ($past(req_i.src) > $past(req_i.dst)))
        else $error("subtract borrow wrong");
    a_shift_carry_out: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_SHIFT && !reg_wr_i |=>
        fc == $past(req_i.shout))
        else $error("shift carry wrong");
    a_scf_sets: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_SCF && !reg_wr_i |=>
        fc)
        else $error("carry not set");
    a_rcf_clears: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_RCF && !reg_wr_i |=>
        !fc)
        else $error("carry not cleared");
    a_ccf_inverts: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_CCF && !reg_wr_i |=>
        fc != $past(fc))
        else $error("carry not inverted");

    // whole-image loads
    a_interrupt_return_instr_reload: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_INTERRUPT_RETURN_INSTR && !reg_wr_i |=>
        flags_o == $past(req_i.data))
        else $error("flags not reloaded");
    a_write_loads: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        reg_wr_i && reg_addr_i == csf_pkg::CSF_FLAGS_ADDR |=>
        flags_o == $past(reg_wdata_i))
        else $error("register write lost");

    // zero and sign
    a_sub_zero_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_SUB && !reg_wr_i |=>
        fz == ($past(req_i.dst) == $past(req_i.src)))
        else $error("subtract zero flag wrong");
    a_test_zero_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_BITTEST && !reg_wr_i |=>
        fz == ($past(req_i.res) == csf_pkg::CSF_ZERO))
        else $error("bit test zero flag wrong");
    a_shift_zero_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_SHIFT && !reg_wr_i |=>
        fz == ($past(req_i.res) == csf_pkg::CSF_ZERO))
        else $error("shift zero flag wrong");
    a_logic_sign_bit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_LOGIC && !reg_wr_i |=>
        fs == $past(req_i.res[7]))
        else $error("logic sign flag wrong");

    // overflow
    a_add_overflow: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_ADD && !reg_wr_i |=>
        fv == $past(ssum[8] ^ ssum[7]))
        else $error("add overflow wrong");
    a_logic_zero_v: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_LOGIC && !reg_wr_i |=>
        !fv && fz == ($past(req_i.res) == csf_pkg::CSF_ZERO))
        else $error("logic flags wrong");

    // decimal and half carry
    a_sub_sets_d: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_SUB && !reg_wr_i |=>
        fd)
        else $error("decimal flag not set");
    a_add_clears_d: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_ADD && !reg_wr_i |=>
        !fd)
        else $error("decimal flag not cleared");
    a_add_half_carry: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_ADD && !reg_wr_i |=>
        fh == ({1'b0, $past(req_i.dst[3:0])} + {1'b0, $past(req_i.src[3:0])} > 5'h0F))
        else $error("half carry wrong");
    // a value that is already decimal after an addition needs no correction
    a_dadj_keeps_bcd: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.op == csf_pkg::CSF_OP_DADJ && !reg_wr_i && !fd && !fh && !fc &&
        req_i.dst[3:0] <= csf_pkg::CSF_BCD_LIMIT && req_i.dst <= csf_pkg::CSF_BCD_HI_LIMIT |=>
        adj_result_o == $past(req_i.dst))
        else $error("decimal adjust changed a decimal value");

    // user bits and condition decode
    a_user_bits_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !reg_wr_i && !(req_i.valid && (req_i.op == csf_pkg::CSF_OP_WRITE ||
        req_i.op == csf_pkg::CSF_OP_INTERRUPT_RETURN_INSTR)) |=> $stable(flags_o[1:0]))
        else $error("user bits changed");
    a_never_taken: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        opcode_i[7:4] == 4'h0 |=>
        !taken_o)
        else $error("never code taken");
    a_always_taken: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        opcode_i[7:4] == 4'h8 |=>
        taken_o)
        else $error("always code not taken");
    a_slt_decode: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        opcode_i[7:4] == 4'h1 |=>
        taken_o == $past(fs ^ fv))
        else $error("signed below wrong");
    a_ugt_decode: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        opcode_i[7:4] == 4'hB |=>
        taken_o == $past(!fc && !fz))
        else $error("unsigned above wrong");

    // main scenarios
    c_wdt_op: cover property (@(posedge mclk_i) req_i.valid && req_i.op == csf_pkg::CSF_OP_WDT);
    c_interrupt_return_instr_op: cover property (@(posedge mclk_i) req_i.valid && req_i.op == csf_pkg::CSF_OP_INTERRUPT_RETURN_INSTR);
    c_dadj_op: cover property (@(posedge mclk_i) req_i.valid && req_i.op == csf_pkg::CSF_OP_DADJ);
    c_shift_op: cover property (@(posedge mclk_i) req_i.valid && req_i.op == csf_pkg::CSF_OP_SHIFT);
    c_taken: cover property (@(posedge mclk_i) taken_o);
endmodule

// ===== logic/csf_pkg.sv
// package: flag register layout, operation codes and condition codes for the status flag block
package csf_pkg;
    localparam logic [7:0] CSF_FLAGS_ADDR = 8'hFC;
    localparam logic [7:0] CSF_FLAGS_RESET = 8'h00;
    // bit positions, from bit 7 down
    localparam int CSF_BIT_C = 7;
    localparam int CSF_BIT_Z = 6;
    localparam int CSF_BIT_S = 5;
    localparam int CSF_BIT_V = 4;
    localparam int CSF_BIT_D = 3;
    localparam int CSF_BIT_H = 2;
    localparam int CSF_BIT_U2 = 1;
    localparam int CSF_BIT_U1 = 0;
    localparam int CSF_CC_LSB = 4;
    localparam int CSF_CC_MSB = 7;
    localparam logic [7:0] CSF_ZERO = 8'h00;
    localparam logic [3:0] CSF_BCD_LIMIT = 4'h9;
    localparam logic [7:0] CSF_BCD_LO = 8'h06;
    localparam logic [7:0] CSF_BCD_HI = 8'h60;
    localparam logic [7:0] CSF_BCD_HI_LIMIT = 8'h99;

    typedef enum logic [3:0] {
        CSF_OP_NONE = 4'h0,
        CSF_OP_ADD = 4'h1,
        CSF_OP_ADC = 4'h2,
        CSF_OP_SUB = 4'h3,
        CSF_OP_SBC = 4'h4,
        CSF_OP_LOGIC = 4'h5,
        CSF_OP_BITTEST = 4'h6,
        CSF_OP_SHIFT = 4'h7,
        CSF_OP_SCF = 4'h8,
        CSF_OP_RCF = 4'h9,
        CSF_OP_CCF = 4'hA,
        CSF_OP_WDT = 4'hB,
        CSF_OP_INTERRUPT_RETURN_INSTR = 4'hC,
        CSF_OP_DADJ = 4'hD,
        CSF_OP_WRITE = 4'hE,
        CSF_OP_INCDEC = 4'hF
    } csf_op_t;

    typedef enum logic [3:0] {
        CSF_CC_NEVER = 4'b0000,
        CSF_CC_SLT = 4'b0001,
        CSF_CC_SLE = 4'b0010,
        CSF_CC_ULE = 4'b0011,
        CSF_CC_OVF = 4'b0100,
        CSF_CC_NEG = 4'b0101,
        CSF_CC_ZER = 4'b0110,
        CSF_CC_CAR = 4'b0111,
        CSF_CC_ALWAYS = 4'b1000,
        CSF_CC_SGE = 4'b1001,
        CSF_CC_SGT = 4'b1010,
        CSF_CC_UGT = 4'b1011,
        CSF_CC_NOVF = 4'b1100,
        CSF_CC_POS = 4'b1101,
        CSF_CC_NZER = 4'b1110,
        CSF_CC_NCAR = 4'b1111
    } csf_cc_t;

    // operation request from the sequencer
    typedef struct packed {
        logic valid;
        csf_op_t op;
        logic [7:0] dst;
        logic [7:0] src;
        logic [7:0] res;
        logic shout;
        logic [7:0] data;
    } csf_req_t;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] adj;
        logic taken;
    } csf_state_t;
endpackage

// ===== logic/csf_cond_eval.sv
// condition code decoder: flag functions selected by a 4-bit field
`timescale 1ns/10ps
module csf_cond_eval (
    input wire logic [3:0] cc_i,
    input wire logic c_i,
    input wire logic z_i,
    input wire logic s_i,
    input wire logic v_i,
    output logic taken_o
);
    logic sxv;
    assign sxv = s_i ^ v_i;

    // only c, z, s and v are inputs, so half-carry and decimal flags cannot be tested
    always_comb begin
        unique case (csf_pkg::csf_cc_t'(cc_i))
            csf_pkg::CSF_CC_NEVER: taken_o = 1'b0;
            csf_pkg::CSF_CC_ALWAYS: taken_o = 1'b1;
            csf_pkg::CSF_CC_CAR: taken_o = c_i;
            csf_pkg::CSF_CC_NCAR: taken_o = ~c_i;
            csf_pkg::CSF_CC_ZER: taken_o = z_i;
            csf_pkg::CSF_CC_NZER: taken_o = ~z_i;
            csf_pkg::CSF_CC_POS: taken_o = ~s_i;
            csf_pkg::CSF_CC_NEG: taken_o = s_i;
            csf_pkg::CSF_CC_OVF: taken_o = v_i;
            csf_pkg::CSF_CC_NOVF: taken_o = ~v_i;
            csf_pkg::CSF_CC_SGE: taken_o = ~sxv;
            csf_pkg::CSF_CC_SLT: taken_o = sxv;
            csf_pkg::CSF_CC_SGT: taken_o = ~(z_i | sxv);
            csf_pkg::CSF_CC_SLE: taken_o = z_i | sxv;
            csf_pkg::CSF_CC_UGT: taken_o = ~c_i & ~z_i;
            csf_pkg::CSF_CC_ULE: taken_o = c_i | z_i;
        endcase
    end
endmodule

// ===== bench/csf_seq_model.sv
// far-side model: sequencer and arithmetic unit handing operation requests to the flag block
`timescale 1ns/10ps
module csf_seq_model (
    output csf_pkg::csf_req_t req_o
);
    initial begin
        req_o = '0;
    end

    // one request, called just after a rising edge; result and shifted-out bit built here
    task automatic issue(input csf_pkg::csf_op_t op, input logic [7:0] d, input logic [7:0] s,
        input logic cin, input logic [7:0] dat);
        logic [8:0] r;
        logic ci;
        ci = cin & (op == csf_pkg::CSF_OP_ADC || op == csf_pkg::CSF_OP_SBC);
        case (op)
            csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADC: r = d + s + ci;
            csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SBC: r = {1'b0, d} - s - ci;
            csf_pkg::CSF_OP_LOGIC: r = {1'b0, d ^ s};
            csf_pkg::CSF_OP_BITTEST: r = {1'b0, d & s};
            // src[0] picks decrement over increment
            csf_pkg::CSF_OP_INCDEC: r = {1'b0, s[0] ? d - 8'h01 : d + 8'h01};
            // src[1:0] picks rotate left, through carry left/right, arithmetic right
            csf_pkg::CSF_OP_SHIFT: r = s[1] ? {d[0], s[0] ? d[7] : cin, d[7:1]}
                : {d, s[0] ? cin : d[7]};
            default: r = {1'b0, d};
        endcase
        // direct flag loads only come as the write operation, which loads the whole flag byte, or the interrupt return
        req_o <= '{1'b1, op, d, s, r[7:0], r[8], dat};
    endtask

    // no request: fields show the inverse of the last value, never a stale copy
    task automatic idle();
        csf_pkg::csf_req_t r;
        r = ~req_o;
        r.valid = 1'b0;
        req_o <= r;
    endtask
endmodule

// ===== bench/test_cpu_status_flags_and_condition_eval.sv
// self-checking bench for the status flag and condition block
`timescale 1ns/10ps
module test_cpu_status_flags_and_condition_eval;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] opcode_i = 8'h00;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    csf_pkg::csf_req_t req_i;
    logic [7:0] reg_rdata_o;
    logic [7:0] flags_o;
    logic [7:0] adj_result_o;
    logic taken_o;
    int bad_count = 0;
    int n_compared = 0;
    int seed = 32'hCE9B05CA;
    logic [7:0] mdl = 8'h00; // model flags as of the last issue or register write
    logic [7:0] cur = 8'h00; // model flags as they stand at the outputs
    logic [7:0] last_res = 8'h00;
    logic [16:0] exp_q[$];
    logic [16:0] e;
    logic v, tk, run;

    csf_seq_model csf_seq_model_i (.req_o(req_i));
    csf_flags csf_flags_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .req_i(req_i), .opcode_i(opcode_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .flags_o(flags_o), .adj_result_o(adj_result_o),
        .taken_o(taken_o));

    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        if (bad_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // sixteen flag functions: low three bits pick one, bit 3 inverts it
    function automatic logic cond(input logic [3:0] cc, input logic [7:0] f);
        logic [7:0] t;
        t = {f[7], f[6], f[5], f[4], f[7] | f[6], f[6] | (f[5] ^ f[4]), f[5] ^ f[4], 1'b0};
        return t[cc[2:0]] ^ cc[3];
    endfunction

    // reference flag update; returns {adjusted value, result, flags}
    function automatic logic [23:0] step(input logic [7:0] f, input int op, input logic [7:0] d,
        input logic [7:0] s, input logic [7:0] dat);
        logic [8:0] r;
        logic [4:0] h;
        logic [7:0] a;
        logic ci;
        ci = f[7] & (op == 2 || op == 4);
        r = {1'b0, d};
        h = 5'h00;
        a = 8'h00;
        case (op)
            1, 2: begin
                r = d + s + ci;
                h = d[3:0] + s[3:0] + ci;
                f[4] = (d[7] == s[7]) && (r[7] != d[7]);
                f[3] = 1'b0;
            end
            3, 4: begin
                r = {1'b0, d} - s - ci;
                h = {1'b0, d[3:0]} - s[3:0] - ci;
                f[4] = (d[7] != s[7]) && (r[7] != d[7]);
                f[3] = 1'b1;
            end
            5, 6: begin
                r = {1'b0, (op == 5) ? d ^ s : d & s};
                f[4] = 1'b0;
            end
            7: begin
                r = s[1] ? {d[0], s[0] ? d[7] : f[7], d[7:1]} : {d, s[0] ? f[7] : d[7]};
                f[4] = d[7] ^ r[7];
            end
            8: f[7] = 1'b1;
            9: f[7] = 1'b0;
            10: f[7] = ~f[7];
            11: f[6:4] = 3'b100;
            12: f[7:2] = dat[7:2];
            13: begin
                a = d;
                if (f[2] || (!f[3] && d[3:0] > 4'h9)) a = f[3] ? a - 8'h06 : a + 8'h06;
                if (f[7] || (!f[3] && d > 8'h99)) a = f[3] ? a - 8'h60 : a + 8'h60;
                f[7] = f[7] || (!f[3] && d > 8'h99);
                f[6] = (a == 8'h00);
                f[5] = a[7];
            end
            14: f = dat;
            15: begin
                r = {1'b0, s[0] ? d - 8'h01 : d + 8'h01};
                f[6] = (r[7:0] == 8'h00);
                f[5] = r[7];
                f[4] = s[0] ? (d == 8'h80) : (d == 8'h7F);
            end
            default: ;
        endcase
        if (op >= 1 && op <= 7) begin
            f[6] = (r[7:0] == 8'h00);
            f[5] = r[7];
            if (op != 5 && op != 6) f[7] = r[8];
            if (op <= 4) f[2] = h[4];
        end
        return {a, r[7:0], f};
    endfunction

    // one cycle of stimulus; a same-cycle register write overrides the whole flag byte
    task automatic cyc(input int op, input logic [7:0] d, input logic [7:0] s, input logic gap,
        input logic nowr);
        logic [7:0] dat, wa, wd;
        logic wr;
        logic [23:0] o;
        @(posedge mclk_i);
        o = '0;
        dat = $random(seed);
        if (op == 12) dat[1:0] = mdl[1:0];
        wr = !nowr && (($random(seed) & 7) == 0);
        wa = ($random(seed) & 1) ? csf_pkg::CSF_FLAGS_ADDR : 8'($random(seed));
        wd = $random(seed);
        reg_wr_i <= wr;
        reg_addr_i <= wa;
        reg_wdata_i <= wd;
        opcode_i <= $random(seed);
        if (gap) begin
            csf_seq_model_i.idle();
        end else begin
            o = step(mdl, op, d, s, dat);
            csf_seq_model_i.issue(csf_pkg::csf_op_t'(op[3:0]), d, s, mdl[7], dat);
            mdl = o[7:0];
            last_res = o[15:8];
        end
        if (wr && wa == csf_pkg::CSF_FLAGS_ADDR) mdl = wd;
        if (!gap || (wr && wa == csf_pkg::CSF_FLAGS_ADDR)) begin
            exp_q.push_back({op == 13 && !gap, o[23:16], mdl});
        end
    endtask

    // compare outputs one cycle after each accepted request or register write
    always @(posedge mclk_i) begin
        v = rstn_i && (req_i.valid === 1'b1
            || (reg_wr_i === 1'b1 && reg_addr_i === csf_pkg::CSF_FLAGS_ADDR));
        tk = cond(opcode_i[7:4], cur);
        run = rstn_i;
        #1;
        if (v) begin
            e = exp_q.pop_front();
            cur = e[7:0];
            check("flags", cur, flags_o);
            if (e[16]) check("adjust", e[15:8], adj_result_o);
        end
        if (run) begin
            check("taken", {7'h00, tk}, {7'h00, taken_o});
            check("rdata", (reg_addr_i == csf_pkg::CSF_FLAGS_ADDR) ? cur : 8'h00,
                reg_rdata_o);
        end
    end

    initial begin
        int n;
        logic [7:0] a, b;
        repeat (6) @(posedge mclk_i);
        check("flags at reset", csf_pkg::CSF_FLAGS_RESET, flags_o);
        check("adjust at reset", 8'h00, adj_result_o);
        check("taken at reset", 8'h00, {7'h00, taken_o});
        rstn_i <= 1'b1;
        // random operation stream with gaps and register writes to mapped and other places
        for (int i = 0; i < 3000; i++) begin
            n = {$random(seed)} % 16;
            if (n == 13) n = 14;
            cyc(n, $random(seed), $random(seed), ({$random(seed)} % 6) == 0, 1'b0);
        end
        // decimal adjust after alternating additions and subtractions of valid decimal operands
        for (int i = 0; i < 60; i++) begin
            a = {4'({$random(seed)} % 10), 4'({$random(seed)} % 10)};
            b = {4'({$random(seed)} % 10), 4'({$random(seed)} % 10)};
            cyc((i % 2) ? 3 : 1, a, b, 1'b0, 1'b1);
            cyc(13, last_res, 8'h00, 1'b0, 1'b1);
        end
        repeat (3) cyc(0, 8'h00, 8'h00, 1'b1, 1'b1);
        end_sim();
    end
endmodule
